//--- rtl/lgc_pkg.sv
/*
  lgc_pkg: constants and carrier types for the display controller global
  control, shadow reload, background colour and interrupt block.
  assumes a 32-bit Avalon-MM register port with byte addresses.
*/
package lgc_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] LGC_OFS_GLOBAL_CONTROL = 8'h18;
  localparam logic [7:0] LGC_OFS_SHADOW_RELOAD = 8'h24;
  localparam logic [7:0] LGC_OFS_BACKGROUND_COLOR = 8'h2c;
  localparam logic [7:0] LGC_OFS_IRQ_ENABLE = 8'h34;
  localparam logic [7:0] LGC_OFS_IRQ_STATUS = 8'h38;
  localparam logic [7:0] LGC_OFS_IRQ_CLEAR = 8'h3c;
  localparam logic [7:0] LGC_OFS_LINE_IRQ_POSITION = 8'h40;
  // shadow window for layer registers: first and last byte offset
  localparam logic [7:0] LGC_OFS_LAYER_FIRST = 8'h84;
  localparam logic [7:0] LGC_OFS_LAYER_LAST = 8'hfc;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int LGC_BIT_HSYNC_POL = 31;
  localparam int LGC_BIT_VSYNC_POL = 30;
  localparam int LGC_BIT_DE_POL = 29;
  localparam int LGC_BIT_PCLK_INV = 28;
  localparam int LGC_BIT_DITHER_ON = 16;
  localparam int LGC_BIT_CTRL_EN = 0;
  localparam int LGC_LSB_DITHER_RED = 12;
  localparam int LGC_LSB_DITHER_GREEN = 8;
  localparam int LGC_LSB_DITHER_BLUE = 4;
  localparam int LGC_BIT_VBLANK_RELOAD = 1;
  localparam int LGC_BIT_IMMEDIATE_RELOAD = 0;
  localparam int LGC_BIT_RELOAD_FLAG = 3;
  localparam int LGC_BIT_BUS_ERROR_FLAG = 2;
  localparam int LGC_BIT_UNDERRUN_FLAG = 1;
  localparam int LGC_BIT_LINE_FLAG = 0;
  localparam int LGC_LINE_W = 11;
  localparam int LGC_NUM_FLAGS = 4;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] LGC_DITHER_WIDTH_RST = 3'h2;
  localparam logic [31:0] LGC_RST_GLOBAL_CONTROL = 32'h0000_2220;
  localparam logic [31:0] LGC_RST_ZERO = 32'h0000_0000;
  localparam int LGC_LAYER_WORDS = 32;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic de;
  } lgc_sync_s;

  typedef struct packed {
    logic reload;
    logic bus_error;
    logic underrun;
    logic line;
  } lgc_flags_s;

endpackage : lgc_pkg

//--- rtl/lgc_ctrl.sv
/*
  lgc_ctrl: global control, shadow reload, background colour and
  interrupt logic of an lcd-tft display controller.
  assumes a single clock, synchronous event inputs from the timing
  generator and fetch datapath, and an Avalon-MM master with waitrequest.
*/
// Chosen here: the Avalon-MM interface to the registers.
// Behaviour
// - hsync polarity bit 31 sets output level
// - vsync polarity bit 30 sets output level
// - data enable polarity bit 29 sets level
// - bit 28 inverts pixel clock when set
// - read-only dither widths at 14:12, 10:8, 6:4
// - bit 0 enables the whole controller
// - vblank reload at first line after active
// - immediate reload copies shadows at once
// - layer registers shadowed except lookup writes
// - shadowed reads return active values
// - 24-bit background colour, read and write
// - enable bits gate each flag onto interrupt
// - reload flag set by vblank reload
// - bus error sets transfer error flag
// - empty fifo read sets underrun flag
// - programmed line reached sets line flag
// - write one to clear register clears flag
// - 11-bit line position, read and write
`timescale 1ns/1ps
module lgc_ctrl
  import lgc_pkg::*;
#(
  parameter int LAYER_WORDS = LGC_LAYER_WORDS,
  parameter logic [7:0] LUT_OFS_L1 = 8'hc4,
  parameter logic [7:0] LUT_OFS_L2 = 8'hc8
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // timing generator and datapath events
  input wire lgc_sync_s i_sync_raw,
  input wire logic i_pixel_clk,
  input wire logic [LGC_LINE_W-1:0] i_scan_line,
  input wire logic i_line_start,
  input wire logic i_after_active,
  input wire logic i_bus_error,
  input wire logic [1:0] i_fifo_empty_read,
  // panel and datapath outputs
  output lgc_sync_s o_sync,
  output logic o_pixel_clk,
  output logic o_dither_on,
  output logic o_controller_enable,
  output logic [23:0] o_background,
  output logic o_reload_pulse,
  output logic [LAYER_WORDS*32-1:0] o_layer_active,
  output logic [31:0] o_lut_wdata,
  output logic [1:0] o_lut_we,
  output logic o_irq
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [3:0] pol_bits;
  logic dither_on;
  logic controller_enable;
  logic vblank_reload;
  logic immediate_reload;
  logic [23:0] background;
  lgc_flags_s irq_enable;
  lgc_flags_s irq_status;
  logic [LGC_LINE_W-1:0] line_irq_line;
  logic [31:0] shadow_mem [LAYER_WORDS];
  logic [31:0] active_mem [LAYER_WORDS];
  logic ack;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire logic req = (i_avs_read | i_avs_write) & ~ack;
  wire logic wr_go = i_avs_write & req & i_ce;
  wire logic hit_gcr = i_avs_address == LGC_OFS_GLOBAL_CONTROL;
  wire logic hit_srl = i_avs_address == LGC_OFS_SHADOW_RELOAD;
  wire logic hit_bg = i_avs_address == LGC_OFS_BACKGROUND_COLOR;
  wire logic hit_ien = i_avs_address == LGC_OFS_IRQ_ENABLE;
  wire logic hit_ist = i_avs_address == LGC_OFS_IRQ_STATUS;
  wire logic hit_icl = i_avs_address == LGC_OFS_IRQ_CLEAR;
  wire logic hit_lip = i_avs_address == LGC_OFS_LINE_IRQ_POSITION;
  wire logic hit_lut = (i_avs_address == LUT_OFS_L1) | (i_avs_address == LUT_OFS_L2);
  wire logic in_layer = (i_avs_address >= LGC_OFS_LAYER_FIRST)
                      & (i_avs_address <= LGC_OFS_LAYER_LAST) & ~hit_lut;
  wire logic [7:0] layer_ofs = i_avs_address - LGC_OFS_LAYER_FIRST;
  wire logic [4:0] layer_idx = layer_ofs[6:2];
  wire logic [31:0] wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                             {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire logic [31:0] wd = i_avs_writedata & wmask;

  // reload triggers
  wire logic vblank_hit = vblank_reload & i_line_start & i_after_active;
  wire logic do_reload = immediate_reload | vblank_hit;

  // flag events and clears; set wins over clear
  wire lgc_flags_s ev = '{reload: vblank_hit,
                          bus_error: i_bus_error,
                          underrun: |i_fifo_empty_read,
                          line: i_line_start & (i_scan_line == line_irq_line)};
  wire lgc_flags_s clr = (wr_go & hit_icl) ? lgc_flags_s'(wd[3:0]) : '0;
  wire lgc_flags_s next_status = ev | (irq_status & ~clr);
  wire lgc_flags_s next_irq_enable = (wr_go & hit_ien & i_avs_byteenable[0])
                                   ? lgc_flags_s'(wd[3:0]) : irq_enable;

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  wire logic [31:0] gcr_rd = {pol_bits, 11'h000, dither_on, 1'b0, LGC_DITHER_WIDTH_RST,
                              1'b0, LGC_DITHER_WIDTH_RST, 1'b0, LGC_DITHER_WIDTH_RST,
                              3'h0, controller_enable};
  wire logic [31:0] next_rdata =
      hit_gcr ? gcr_rd :
      hit_srl ? {30'h0, vblank_reload, immediate_reload} :
      hit_bg ? {8'h00, background} :
      hit_ien ? {28'h0, irq_enable} :
      hit_ist ? {28'h0, irq_status} :
      hit_lip ? {21'h0, line_irq_line} :
      in_layer ? active_mem[layer_idx] : LGC_RST_ZERO;

  // ----------------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack <= 1'b0;
      o_avs_readdata <= LGC_RST_ZERO;
    end else if (i_ce) begin
      ack <= req;
      if (req) begin
        o_avs_readdata <= i_avs_read ? next_rdata : LGC_RST_ZERO;
      end
    end
  end
  assign o_avs_waitrequest = ~ack;

  // ----------------------------------------------------------------------
  // global control, colour, enable and position registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pol_bits <= 4'h0;
      dither_on <= 1'b0;
      controller_enable <= 1'b0;
      background <= 24'h000000;
      irq_enable <= '0;
      line_irq_line <= '0;
    end else if (wr_go) begin
      if (hit_gcr && i_avs_byteenable[3]) begin
        pol_bits <= wd[LGC_BIT_HSYNC_POL:LGC_BIT_PCLK_INV];
      end
      if (hit_gcr && i_avs_byteenable[2]) begin
        dither_on <= wd[LGC_BIT_DITHER_ON];
      end
      if (hit_gcr && i_avs_byteenable[0]) begin
        controller_enable <= wd[LGC_BIT_CTRL_EN];
      end
      if (hit_bg) begin
        background <= (background & ~wmask[23:0]) | wd[23:0];
      end
      if (hit_ien && i_avs_byteenable[0]) begin
        irq_enable <= lgc_flags_s'(wd[3:0]);
      end
      if (hit_lip) begin
        line_irq_line <= (line_irq_line & ~wmask[10:0]) | wd[10:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // reload requests: software sets, only hardware clears
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vblank_reload <= 1'b0;
      immediate_reload <= 1'b0;
    end else if (i_ce) begin
      immediate_reload <= (wr_go & hit_srl & wd[LGC_BIT_IMMEDIATE_RELOAD]);
      vblank_reload <= (vblank_reload & ~vblank_hit)
                     | (wr_go & hit_srl & wd[LGC_BIT_VBLANK_RELOAD]);
    end
  end

  // ----------------------------------------------------------------------
  // layer shadow and active copies, one entry per word
  // ----------------------------------------------------------------------
  for (genvar gi = 0; gi < LAYER_WORDS; gi++) begin : g_layer
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        shadow_mem[gi] <= LGC_RST_ZERO;
        active_mem[gi] <= LGC_RST_ZERO;
      end else if (i_ce) begin
        if (wr_go && in_layer && layer_idx == 5'(gi)) begin
          shadow_mem[gi] <= (shadow_mem[gi] & ~wmask) | wd;
        end
        if (do_reload) begin
          active_mem[gi] <= shadow_mem[gi];
        end
      end
    end
    assign o_layer_active[gi*32 +: 32] = active_mem[gi];
  end

  // ----------------------------------------------------------------------
  // status flags and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_status <= '0;
      o_irq <= 1'b0;
      o_sync <= '0;
      o_pixel_clk <= 1'b0;
      o_dither_on <= 1'b0;
      o_controller_enable <= 1'b0;
      o_background <= 24'h000000;
      o_reload_pulse <= 1'b0;
      o_lut_wdata <= LGC_RST_ZERO;
      o_lut_we <= 2'b00;
    end else if (i_ce) begin
      irq_status <= next_status;
      o_irq <= |(next_status & next_irq_enable);
      o_sync.hsync <= i_sync_raw.hsync ~^ pol_bits[3];
      o_sync.vsync <= i_sync_raw.vsync ~^ pol_bits[2];
      o_sync.de <= i_sync_raw.de ~^ pol_bits[1];
      o_pixel_clk <= i_pixel_clk ^ pol_bits[0];
      o_dither_on <= dither_on;
      o_controller_enable <= controller_enable;
      o_background <= background;
      o_reload_pulse <= do_reload;
      o_lut_wdata <= wd;
      o_lut_we <= {wr_go & (i_avs_address == LUT_OFS_L2),
                   wr_go & (i_avs_address == LUT_OFS_L1)};
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_clear_write;
    wr_go && hit_icl && wd[LGC_BIT_LINE_FLAG] && !ev.line;
  endsequence

  a_hsync_polarity: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_sync.hsync == ($past(i_sync_raw.hsync) ~^ $past(pol_bits[3])))
    else $error("hsync polarity wrong");
  a_vsync_polarity: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_sync.vsync == ($past(i_sync_raw.vsync) ~^ $past(pol_bits[2])))
    else $error("vsync polarity wrong");
  a_pclk_invert: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_pixel_clk == ($past(i_pixel_clk) ^ $past(pol_bits[0])))
    else $error("pixel clock inversion wrong");
  a_imm_reload_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && immediate_reload |=> !immediate_reload || $past(wr_go && hit_srl))
    else $error("immediate reload not self clearing");
  a_vblank_reload_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    vblank_reload && !vblank_hit |=> vblank_reload)
    else $error("vblank reload cleared early");
  a_reload_flag_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && vblank_hit |=> irq_status.reload && o_reload_pulse)
    else $error("reload flag not set");
  a_line_flag_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_line_start && i_scan_line == line_irq_line |=> irq_status.line)
    else $error("line flag not set");
  a_line_flag_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_clear_write |=> !irq_status.line)
    else $error("line flag not cleared");
  a_irq_output: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_irq == |(irq_status & irq_enable))
    else $error("interrupt output mismatch");
  a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && req |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");

  // ----------------------------------------------------------------------
  // further checks on outputs, reloads and flags
  // ----------------------------------------------------------------------
  sequence s_vblank_fire;
    i_ce && vblank_hit && !(wr_go && hit_srl && wd[LGC_BIT_VBLANK_RELOAD]);
  endsequence
  sequence s_clear_bus_error;
    wr_go && hit_icl && wd[LGC_BIT_BUS_ERROR_FLAG] && !ev.bus_error;
  endsequence

  // polarity and plain register copies
  a_de_polarity: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_sync.de == ($past(i_sync_raw.de) ~^ $past(pol_bits[1])))
    else $error("data enable polarity wrong");
  a_pol_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !(wr_go && hit_gcr) |=> $stable(pol_bits))
    else $error("polarity bits changed without write");
  a_dither_output: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_dither_on == $past(dither_on))
    else $error("dither output wrong");
  a_enable_output: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_controller_enable == $past(controller_enable))
    else $error("controller enable output wrong");
  a_bg_output: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce |=> o_background == $past(background))
    else $error("background output wrong");
  a_bg_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !(wr_go && hit_bg) |=> $stable(background))
    else $error("background changed without write");
  a_pos_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !(wr_go && hit_lip) |=> $stable(line_irq_line))
    else $error("line position changed without write");
  a_ien_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !(wr_go && hit_ien) |=> $stable(irq_enable))
    else $error("interrupt enable changed without write");

  // reload requests and shadow copies
  a_vblank_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr_go && hit_srl && wd[LGC_BIT_VBLANK_RELOAD] |=> vblank_reload)
    else $error("vblank reload not armed");
  a_vblank_self_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_vblank_fire |=> !vblank_reload)
    else $error("vblank reload not cleared by hardware");
  a_imm_reload_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr_go && hit_srl && wd[LGC_BIT_IMMEDIATE_RELOAD] |=> immediate_reload)
    else $error("immediate reload not armed");
  a_imm_write_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr_go && hit_srl && !wd[LGC_BIT_IMMEDIATE_RELOAD] |=> !immediate_reload)
    else $error("zero write armed immediate reload");
  a_imm_copy: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && immediate_reload |=> o_reload_pulse)
    else $error("immediate reload did not copy");
  a_lut_bypass_l1: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr_go && i_avs_address == LUT_OFS_L1 |=> o_lut_we[0] && o_lut_wdata == $past(wd))
    else $error("first lookup write not passed on");
  a_lut_bypass_l2: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr_go && i_avs_address == LUT_OFS_L2 |=> o_lut_we[1] && o_lut_wdata == $past(wd))
    else $error("second lookup write not passed on");
  a_active_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !do_reload |=> $stable(o_layer_active))
    else $error("active copy changed without reload");

  // status flags and bus
  a_bus_error_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_bus_error |=> irq_status.bus_error)
    else $error("transfer error flag not set");
  a_underrun_set: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && |i_fifo_empty_read |=> irq_status.underrun)
    else $error("underrun flag not set");
  a_line_no_spurious: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && !ev.line && !irq_status.line |=> !irq_status.line)
    else $error("line flag set without event");
  a_bus_error_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_clear_bus_error |=> !irq_status.bus_error)
    else $error("transfer error flag not cleared");
  a_reload_flag_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr_go && hit_icl && wd[LGC_BIT_RELOAD_FLAG] && !ev.reload |=> !irq_status.reload)
    else $error("reload flag not cleared");
  a_underrun_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr_go && hit_icl && wd[LGC_BIT_UNDERRUN_FLAG] && !ev.underrun |=> !irq_status.underrun)
    else $error("underrun flag not cleared");
  a_ack_single: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && ack |=> !ack)
    else $error("answer longer than one cycle");

endmodule : lgc_ctrl

//--- test/lgc_panel_model.sv
/*
  lgc_panel_model: far-side model that sources raw sync phases, the
  pixel clock and line events toward the controller.
  assumes one clock; the bench requests each line start via i_fire.
*/
`timescale 1ns/1ps
module lgc_panel_model
  import lgc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // line request from the bench
  input wire logic i_fire,
  input wire logic [LGC_LINE_W-1:0] i_line,
  input wire logic i_after,
  // timing toward the controller
  output lgc_sync_s o_sync_raw,
  output logic o_pixel_clk,
  output logic [LGC_LINE_W-1:0] o_scan_line,
  output logic o_line_start,
  output logic o_after_active
);
  // ----------------------------------------------------------------------
  // phase counter and line events
  // ----------------------------------------------------------------------
  logic [3:0] phase;

  // line number and blanking flag only hold while a line starts
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= 4'h0;
      o_line_start <= 1'b0;
      o_scan_line <= '0;
      o_after_active <= 1'b0;
    end else begin
      phase <= phase + 4'h1;
      o_line_start <= i_fire;
      o_scan_line <= i_fire ? i_line : ~o_scan_line;
      o_after_active <= i_fire ? i_after : ~o_after_active;
    end
  end

  // every raw combination shows up within sixteen cycles
  assign o_sync_raw = lgc_sync_s'(phase[3:1]);
  assign o_pixel_clk = phase[0];
endmodule : lgc_panel_model

//--- test/lcd_global_ctrl_irq_bench.sv
/*
  lcd_global_ctrl_irq_bench: self-checking bench for lgc_ctrl.
  assumes lgc_pkg and the panel model; registers reached over avalon-mm.
*/
`timescale 1ns/1ps
module lcd_global_ctrl_irq_bench;
  import lgc_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus, observation and dut
  // ----------------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic bus_err = 1'b0;
  logic ce = 1'b1;
  logic [1:0] fifo_rd = 2'h0;
  logic fire = 1'b0;
  logic [LGC_LINE_W-1:0] fire_line = '0;
  logic fire_after = 1'b0;
  logic [31:0] rdat, rdq;
  logic wreq, pclk_raw, pclk_d, pclk, dith, cen, irq, lstart, after;
  logic [LGC_LINE_W-1:0] scan;
  lgc_sync_s raw, raw_d, sync;
  logic [23:0] bg;
  logic [LGC_LAYER_WORDS*32-1:0] act;
  logic [31:0] gv [3] = '{32'hffff_ffff, 32'h0000_0000, 32'h5001_0000};
  logic [7:0] ofs [8] = '{LGC_OFS_GLOBAL_CONTROL, LGC_OFS_SHADOW_RELOAD,
    LGC_OFS_BACKGROUND_COLOR, LGC_OFS_IRQ_ENABLE, LGC_OFS_IRQ_STATUS,
    LGC_OFS_IRQ_CLEAR, LGC_OFS_LINE_IRQ_POSITION, 8'h00};
  int n_fail = 0;
  int checks = 0;

  always #2 i_clk = ~i_clk;

  // what the dut sampled at the last edge
  always @(posedge i_clk) begin
    raw_d <= raw;
    pclk_d <= pclk_raw;
  end

  lgc_panel_model panel (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_fire(fire),
    .i_line(fire_line), .i_after(fire_after), .o_sync_raw(raw),
    .o_pixel_clk(pclk_raw), .o_scan_line(scan), .o_line_start(lstart),
    .o_after_active(after));

  lgc_ctrl DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce),
    .i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_sync_raw(raw), .i_pixel_clk(pclk_raw),
    .i_scan_line(scan), .i_line_start(lstart), .i_after_active(after),
    .i_bus_error(bus_err), .i_fifo_empty_read(fifo_rd), .o_sync(sync),
    .o_pixel_clk(pclk), .o_dither_on(dith), .o_controller_enable(cen),
    .o_background(bg), .o_reload_pulse(), .o_layer_active(act),
    .o_lut_wdata(), .o_lut_we(), .o_irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wr_en <= wr;
    rd_en <= !wr;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 64);
    rdq = rdat;
    chk({31'h0, wreq}, 32'h0);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdq, exp);
  endtask : rd_chk

  task automatic pins(input logic [31:0] g);
    repeat (8) begin
      @(negedge i_clk);
      chk({29'h0, sync}, {29'h0, raw_d ~^ g[31:29]});
      chk({31'h0, pclk}, {31'h0, pclk_d ^ g[28]});
    end
    chk({30'h0, dith, cen}, {30'h0, g[16], g[0]});
  endtask : pins

  task automatic ev(input logic b, input logic [1:0] f);
    @(posedge i_clk);
    bus_err <= b;
    fifo_rd <= f;
    @(posedge i_clk);
    bus_err <= 1'b0;
    fifo_rd <= 2'h0;
    repeat (2) @(posedge i_clk);
  endtask : ev

  task automatic line_go(input logic [LGC_LINE_W-1:0] l, input logic a);
    @(posedge i_clk);
    fire <= 1'b1;
    fire_line <= l;
    fire_after <= a;
    @(posedge i_clk);
    fire <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : line_go

  task automatic irq_is(input logic v);
    @(negedge i_clk);
    chk({31'h0, irq}, {31'h0, v});
  endtask : irq_is

  task automatic close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // cut a hang short
  initial begin
    #40000;
    n_fail++;
    close_out;
  end

  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    bus(1'b1, LGC_OFS_IRQ_STATUS, 32'hf);
    bus(1'b1, 8'h00, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ofs[i], (i == 0) ? LGC_RST_GLOBAL_CONTROL : LGC_RST_ZERO);
    end
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, LGC_OFS_GLOBAL_CONTROL, gv[i]);
      rd_chk(LGC_OFS_GLOBAL_CONTROL, (gv[i] & 32'hf001_0001) | 32'h2220);
      pins(gv[i]);
    end
    bus(1'b1, LGC_OFS_BACKGROUND_COLOR, 32'hffab_cdef);
    rd_chk(LGC_OFS_BACKGROUND_COLOR, 32'h00ab_cdef);
    chk({8'h0, bg}, 32'h00ab_cdef);
    // layer words visible only after a reload
    bus(1'b1, 8'h84, 32'h1234_5678);
    rd_chk(8'h84, 32'h0);
    bus(1'b1, LGC_OFS_SHADOW_RELOAD, 32'h0);
    rd_chk(8'h84, 32'h0);
    bus(1'b1, LGC_OFS_SHADOW_RELOAD, 32'h1);
    rd_chk(8'h84, 32'h1234_5678);
    rd_chk(LGC_OFS_SHADOW_RELOAD, 32'h0);
    chk(act[31:0], 32'h1234_5678);
    bus(1'b1, 8'h88, 32'h0bad_f00d);
    bus(1'b1, LGC_OFS_SHADOW_RELOAD, 32'h2);
    bus(1'b1, LGC_OFS_SHADOW_RELOAD, 32'h0);
    line_go(11'h005, 1'b0);
    rd_chk(LGC_OFS_SHADOW_RELOAD, 32'h2);
    rd_chk(8'h88, 32'h0);
    line_go(11'h00a, 1'b1);
    rd_chk(LGC_OFS_SHADOW_RELOAD, 32'h0);
    rd_chk(8'h88, 32'h0bad_f00d);
    chk(act[63:32], 32'h0bad_f00d);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h8);
    bus(1'b1, LGC_OFS_IRQ_CLEAR, 32'h8);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h0);
    bus(1'b1, LGC_OFS_IRQ_ENABLE, 32'hffff_fff4);
    rd_chk(LGC_OFS_IRQ_ENABLE, 32'h4);
    ev(1'b0, 2'b10);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h2);
    irq_is(1'b0);
    ev(1'b1, 2'b00);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h6);
    irq_is(1'b1);
    bus(1'b1, LGC_OFS_IRQ_CLEAR, 32'h0);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h6);
    bus(1'b1, LGC_OFS_IRQ_CLEAR, 32'h4);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h2);
    irq_is(1'b0);
    bus(1'b1, LGC_OFS_IRQ_CLEAR, 32'h2);
    ev(1'b0, 2'b01);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h2);
    bus(1'b1, LGC_OFS_LINE_IRQ_POSITION, 32'hffff_f7ff);
    rd_chk(LGC_OFS_LINE_IRQ_POSITION, 32'h7ff);
    line_go(11'h7fe, 1'b0);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h2);
    line_go(11'h7ff, 1'b0);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h3);
    bus(1'b1, LGC_OFS_IRQ_ENABLE, 32'h1);
    irq_is(1'b1);
    bus(1'b1, LGC_OFS_IRQ_CLEAR, 32'hf);
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h0);
    irq_is(1'b0);
    // lookup writes bypass the shadow window
    bus(1'b1, 8'hc4, 32'hcafe_0001);
    bus(1'b1, LGC_OFS_SHADOW_RELOAD, 32'h1);
    rd_chk(8'hc4, 32'h0);
    chk(act[16*32 +: 32], 32'h0);
    // frozen clock enable ignores events
    @(posedge i_clk);
    ce <= 1'b0;
    ev(1'b1, 2'b11);
    ce <= 1'b1;
    rd_chk(LGC_OFS_IRQ_STATUS, 32'h0);
    close_out;
  end
endmodule : lcd_global_ctrl_irq_bench
